// *** hw/card_access_pkg.sv ***
// Behaviour
// - both variants share fabrication, issuer, code, tally and guarded zones.
// - single-zone variant places app one, 32-bit key one, budget, test zone.
// - two-zone variant adds app two and key two; key one is 48 bits.
// - maker lock fuse blown forbids erase and program of fabrication zone.
// - personalization fuse blown makes the issuer zone read-only.
// - pad level and fuse states choose factory, personalization or issued-card rules.
// - code valid flag rises only after the access code validates.
// - after personalization, application zones need a validated code to program or erase; reading needs the code or the read gate bit.
// - wrong code tally counts bad codes; four make the card locked.
// - app zone one gated by write bit 176, read bit 177, code valid.
// - two-zone variant gates app zone two by bits 736 and 737.
// - issued card: app zone erase only while that zone's own key flag is set.
// - keys programmed during personalization; afterwards compare only.
// - issued card: last zone erasures limited by budget; available flag while nonempty.
// - personalization, code invalid: read, compare, tally/budget/test program, test erase only.
// - personalization, code valid: read erase program everywhere but fabrication.
// - issued: fabrication and issuer read-only; code compare or rewrite.
// - issued: budget read/program; app zones without code denied or read by gate.
// - test pattern zone always allows read, erase and program.
// - guarded zone write and erase only with validated code.
// - data output held high where reading is forbidden.
// - compare accepted only at code or erase key addresses.
package card_access_pkg;
  localparam int        ADDR_W      = 11;
  localparam logic [10:0] FAB_LO     = 11'h000;
  localparam logic [10:0] ISS_LO     = 11'h010;
  localparam logic [10:0] CODE_LO    = 11'h050;
  localparam logic [10:0] CODE_HI    = 11'h05f;
  localparam logic [10:0] TALLY_LO   = 11'h060;
  localparam logic [10:0] GUARD_LO   = 11'h070;
  localparam logic [10:0] APP1_LO    = 11'h0b0;
  localparam logic [10:0] APP1_RD    = 11'h0b1;
  localparam logic [10:0] S_KEY1_LO  = 11'h4b0;
  localparam logic [10:0] S_KEY1_HI  = 11'h4cf;
  localparam logic [10:0] S_BUDG_LO  = 11'h4d0;
  localparam logic [10:0] S_TEST_LO  = 11'h550;
  localparam logic [10:0] S_TEST_HI  = 11'h55f;
  localparam logic [10:0] D_KEY1_LO  = 11'h2b0;
  localparam logic [10:0] D_KEY1_HI  = 11'h2df;
  localparam logic [10:0] D_APP2_LO  = 11'h2e0;
  localparam logic [10:0] D_APP2_RD  = 11'h2e1;
  localparam logic [10:0] D_KEY2_LO  = 11'h4e0;
  localparam logic [10:0] D_KEY2_HI  = 11'h4ff;
  localparam logic [10:0] D_BUDG_LO  = 11'h500;
  localparam logic [10:0] D_TEST_LO  = 11'h580;
  localparam logic [10:0] D_TEST_HI  = 11'h58f;
  localparam logic [2:0] TALLY_MAX   = 3'h4;
  // operation codes
  localparam logic [1:0] OP_READ     = 2'h0;
  localparam logic [1:0] OP_ERASE    = 2'h1;
  localparam logic [1:0] OP_PROG     = 2'h2;
  localparam logic [1:0] OP_CMP      = 2'h3;
  // zone codes
  localparam logic [3:0] Z_FAB       = 4'h0;
  localparam logic [3:0] Z_ISS       = 4'h1;
  localparam logic [3:0] Z_CODE      = 4'h2;
  localparam logic [3:0] Z_TALLY     = 4'h3;
  localparam logic [3:0] Z_GUARD     = 4'h4;
  localparam logic [3:0] Z_APP1      = 4'h5;
  localparam logic [3:0] Z_KEY1      = 4'h6;
  localparam logic [3:0] Z_APP2      = 4'h7;
  localparam logic [3:0] Z_KEY2      = 4'h8;
  localparam logic [3:0] Z_BUDG      = 4'h9;
  localparam logic [3:0] Z_TEST      = 4'ha;
  localparam logic [3:0] Z_NONE      = 4'hf;
  // rule modes
  localparam logic [1:0] M_FACTORY   = 2'h0;
  localparam logic [1:0] M_PERSO     = 2'h1;
  localparam logic [1:0] M_ISSUED    = 2'h2;
  // register map (byte addresses) and fields
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STAT    = 4'h4;
  localparam int        CTRL_TWO    = 0;
  localparam int        CTRL_MAKER  = 1;
  localparam int        CTRL_PERS   = 2;
  localparam int        ST_VALID    = 0;
  localparam int        ST_KEY1     = 1;
  localparam int        ST_KEY2     = 2;
  localparam int        ST_LOCK     = 3;
  localparam int        ST_TALLY    = 4;
  localparam int        ST_MODE     = 7;
  localparam int        ST_BUDG     = 9;
endpackage

// *** hw/card_access.sv ***
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module card_access
  import card_access_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic [3:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic              lock_sense_pad_in,
  input  wire logic              op_valid_in,
  input  wire logic [1:0]        op_kind_in,
  input  wire logic [ADDR_W-1:0] bit_addr_in,
  input  wire logic              stored_bit_in,
  input  wire logic              present_bit_in,
  input  wire logic              budget_nonempty_in,
  output logic                   op_done_out,
  output logic                   op_grant_out,
  output logic                   data_bit_out,
  output logic      [3:0]        zone_out,
  output logic                   code_valid_out,
  output logic                   erase_avail_out,
  output logic                   locked_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic        two_zone_r;
  logic        maker_lock_fuse_r;
  logic        personalization_fuse_r;
  logic        code_valid_r;
  logic        key_one_ok_r;
  logic        key_two_ok_r;
  logic        mismatch_r;
  logic [2:0]  wrong_code_tally_r;
  logic        w_gate_one_r;
  logic        r_gate_one_r;
  logic        w_gate_two_r;
  logic        r_gate_two_r;
  logic        avs_waitrequest_r;
  logic [31:0] avs_readdata_r;
  logic        op_done_r;
  logic        op_grant_r;
  logic        data_bit_r;
  logic [3:0]  zone_r;
  logic        erase_avail_r;
  logic        locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire [10:0] a = bit_addr_in;
  wire [10:0] key1_lo = two_zone_r ? D_KEY1_LO : S_KEY1_LO;
  wire [10:0] key1_hi = two_zone_r ? D_KEY1_HI : S_KEY1_HI;
  wire [10:0] budg_lo = two_zone_r ? D_BUDG_LO : S_BUDG_LO;
  wire [10:0] test_lo = two_zone_r ? D_TEST_LO : S_TEST_LO;
  wire [10:0] test_hi = two_zone_r ? D_TEST_HI : S_TEST_HI;
  wire in_fab   = a < ISS_LO;
  wire in_iss   = a >= ISS_LO && a < CODE_LO;
  wire in_code  = a >= CODE_LO && a < TALLY_LO;
  wire in_tally = a >= TALLY_LO && a < GUARD_LO;
  wire in_guard = a >= GUARD_LO && a < APP1_LO;
  wire in_app1  = a >= APP1_LO && a < key1_lo;
  wire in_key1  = a >= key1_lo && a <= key1_hi;
  wire in_app2  = two_zone_r && a >= D_APP2_LO && a < D_KEY2_LO;
  wire in_key2  = two_zone_r && a >= D_KEY2_LO && a <= D_KEY2_HI;
  wire in_budg  = a >= budg_lo && a < test_lo;
  wire in_test  = a >= test_lo && a <= test_hi;

  logic [3:0] zone;
  always_comb begin
    zone = Z_NONE;
    if (in_fab) zone = Z_FAB;
    else if (in_iss) zone = Z_ISS;
    else if (in_code) zone = Z_CODE;
    else if (in_tally) zone = Z_TALLY;
    else if (in_guard) zone = Z_GUARD;
    else if (in_app1) zone = Z_APP1;
    else if (in_key1) zone = Z_KEY1;
    else if (in_app2) zone = Z_APP2;
    else if (in_key2) zone = Z_KEY2;
    else if (in_budg) zone = Z_BUDG;
    else if (in_test) zone = Z_TEST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // rule mode
  logic [1:0] mode;
  assign mode = (!lock_sense_pad_in ||
                 (maker_lock_fuse_r && personalization_fuse_r)) ? M_ISSUED :
                maker_lock_fuse_r ? M_PERSO : M_FACTORY;
  wire issued = mode == M_ISSUED;
  wire cv     = code_valid_r;
  wire locked = locked_r;

  // app zone gate selection
  wire is_app   = zone == Z_APP1 || zone == Z_APP2;
  wire w_gate   = (zone == Z_APP2) ? w_gate_two_r : w_gate_one_r;
  wire r_gate   = (zone == Z_APP2) ? r_gate_two_r : r_gate_one_r;
  wire key_ok   = (zone == Z_APP2) ? key_two_ok_r : key_one_ok_r;
  wire last_app = (zone == Z_APP2) || !two_zone_r;

  ////////////////////////////////////////////////////////////////////////////
  // permission table: rd, er, pg, cmp
  logic p_rd;
  logic p_er;
  logic p_pg;
  logic p_cmp;
  always_comb begin
    p_rd  = 1'b0;
    p_er  = 1'b0;
    p_pg  = 1'b0;
    p_cmp = 1'b0;
    case (zone)
      Z_FAB: begin
        p_rd = 1'b1;
        // fuse or issue freezes fab zone
        p_er = !maker_lock_fuse_r && !issued;
        p_pg = !maker_lock_fuse_r && !issued;
      end
      Z_ISS: begin
        p_rd = 1'b1;
        p_er = !issued && cv && !personalization_fuse_r;
        p_pg = !issued && cv && !personalization_fuse_r;
      end
      Z_CODE: begin
        p_rd  = cv && !issued;
        p_er  = cv;
        p_pg  = cv;
        p_cmp = !cv;
      end
      Z_TALLY, Z_GUARD: begin
        p_rd = 1'b1;
        p_er = cv;
        p_pg = cv || zone == Z_TALLY;
      end
      Z_APP1, Z_APP2: begin
        p_rd = cv || r_gate;
        p_pg = cv && (!issued || w_gate);
        p_er = cv && (!issued || (key_ok &&
               (!last_app || budget_nonempty_in)));
      end
      Z_KEY1, Z_KEY2: begin
        p_rd  = !issued && cv;
        p_er  = !issued && cv;
        p_pg  = !issued && cv;
        p_cmp = issued;
      end
      Z_BUDG: begin
        p_rd = 1'b1;
        p_pg = 1'b1;
        p_er = !issued && cv;
      end
      Z_TEST: begin
        p_rd = 1'b1;
        p_er = 1'b1;
        p_pg = 1'b1;
      end
      default: begin
        p_rd = 1'b0;
      end
    endcase
  end

  wire allow_raw = (op_kind_in == OP_READ)  ? p_rd :
                   (op_kind_in == OP_ERASE) ? p_er :
                   (op_kind_in == OP_PROG)  ? p_pg : p_cmp;
  // locked card refuses everything but the test zone
  wire allow = allow_raw && (!locked || zone == Z_TEST);

  ////////////////////////////////////////////////////////////////////////////
  // compare sequencing
  // compare only at code and key addresses
  wire cmp_op   = op_valid_in && op_kind_in == OP_CMP && allow;
  wire cmp_code = cmp_op && zone == Z_CODE;
  wire cmp_key1 = cmp_op && zone == Z_KEY1;
  wire cmp_key2 = cmp_op && zone == Z_KEY2;
  wire first_bit = (cmp_code && a == CODE_LO) ||
                   (cmp_key1 && a == key1_lo) ||
                   (cmp_key2 && a == D_KEY2_LO);
  wire last_bit  = (cmp_code && a == CODE_HI) ||
                   (cmp_key1 && a == key1_hi) ||
                   (cmp_key2 && a == D_KEY2_HI);
  // any differing bit spoils the presentation
  wire mismatch_nxt = (first_bit ? 1'b0 : mismatch_r) |
                      (present_bit_in ^ stored_bit_in);
  wire good_end = last_bit && !mismatch_nxt;
  wire bad_code = last_bit && mismatch_nxt && cmp_code;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mismatch_r         <= 1'b1;
      code_valid_r       <= 1'b0;
      key_one_ok_r       <= 1'b0;
      key_two_ok_r       <= 1'b0;
    end else if (cmp_op) begin
      mismatch_r <= mismatch_nxt;
      // flag set only on good code
      if (cmp_code && first_bit) code_valid_r <= 1'b0;
      else if (cmp_code && good_end) code_valid_r <= 1'b1;
      if (cmp_key1 && first_bit) key_one_ok_r <= 1'b0;
      else if (cmp_key1 && good_end) key_one_ok_r <= 1'b1;
      if (cmp_key2 && first_bit) key_two_ok_r <= 1'b0;
      else if (cmp_key2 && good_end) key_two_ok_r <= 1'b1;
    end
  end

  // tally counts bad codes, good code clears
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wrong_code_tally_r <= 3'h0;
      locked_r           <= 1'b0;
    end else if (bad_code && !locked) begin
      wrong_code_tally_r <= wrong_code_tally_r + 3'h1;
      locked_r           <= wrong_code_tally_r == TALLY_MAX - 3'h1;
    end else if (cmp_code && good_end) begin
      wrong_code_tally_r <= 3'h0;
      locked_r           <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate bit snooping
  wire gate_bit = (op_kind_in == OP_ERASE && allow) ? 1'b1 :
                  (op_kind_in == OP_PROG && allow)  ? 1'b0 : stored_bit_in;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      w_gate_one_r <= 1'b0;
      r_gate_one_r <= 1'b0;
      w_gate_two_r <= 1'b0;
      r_gate_two_r <= 1'b0;
    end else if (op_valid_in && op_kind_in != OP_CMP) begin
      if (a == APP1_LO) w_gate_one_r <= gate_bit;
      if (a == APP1_RD) r_gate_one_r <= gate_bit;
      if (two_zone_r && a == D_APP2_LO) w_gate_two_r <= gate_bit;
      if (two_zone_r && a == D_APP2_RD) r_gate_two_r <= gate_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation answer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      op_done_r     <= 1'b0;
      op_grant_r    <= 1'b0;
      data_bit_r    <= 1'b1;
      zone_r        <= Z_NONE;
      erase_avail_r <= 1'b0;
    end else begin
      op_done_r     <= op_valid_in;
      erase_avail_r <= budget_nonempty_in;
      if (op_valid_in) begin
        op_grant_r <= allow;
        zone_r     <= zone;
        data_bit_r <= (p_rd && (!locked || zone == Z_TEST)) ?
                      stored_bit_in : 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave
  wire req      = avs_read_in || avs_write_in;
  wire wr_take  = avs_write_in && !avs_waitrequest_r;
  wire sel_ctrl = avs_address_in == REG_CTRL;
  wire sel_stat = avs_address_in == REG_STAT;
  wire [31:0] ctrl_word = {29'h0, personalization_fuse_r,
                           maker_lock_fuse_r, two_zone_r};
  wire [31:0] stat_word = {22'h0, erase_avail_r, mode, wrong_code_tally_r,
                           locked, key_two_ok_r, key_one_ok_r, code_valid_r};
  wire [31:0] rd_word   = sel_ctrl ? ctrl_word :
                          sel_stat ? stat_word : 32'h0;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      avs_waitrequest_r <= 1'b1;
      avs_readdata_r    <= 32'h0;
    end else begin
      avs_waitrequest_r <= !(req && avs_waitrequest_r);
      if (avs_read_in && avs_waitrequest_r) avs_readdata_r <= rd_word;
    end
  end

  // fuses only ever blow
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      two_zone_r             <= 1'b0;
      maker_lock_fuse_r      <= 1'b0;
      personalization_fuse_r <= 1'b0;
    end else if (wr_take && sel_ctrl && avs_byteenable_in[0]) begin
      two_zone_r <= avs_writedata_in[CTRL_TWO];
      if (avs_writedata_in[CTRL_MAKER]) maker_lock_fuse_r <= 1'b1;
      if (avs_writedata_in[CTRL_PERS]) personalization_fuse_r <= 1'b1;
    end
  end

  assign avs_readdata_out    = avs_readdata_r;
  assign avs_waitrequest_out = avs_waitrequest_r;
  assign op_done_out         = op_done_r;
  assign op_grant_out        = op_grant_r;
  assign data_bit_out        = data_bit_r;
  assign zone_out            = zone_r;
  assign code_valid_out      = code_valid_r;
  assign erase_avail_out     = erase_avail_r;
  assign locked_out          = locked_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_fab_frozen;
    @(posedge clk_in) disable iff (reset_in)
      op_valid_in && zone == Z_FAB && op_kind_in != OP_READ &&
      maker_lock_fuse_r |=> !op_grant_r;
  endproperty
  a_fab_frozen: assert property (p_fab_frozen) else $error("fab write ok");

  property p_iss_ro;
    @(posedge clk_in) disable iff (reset_in)
      op_valid_in && zone == Z_ISS && personalization_fuse_r &&
      op_kind_in != OP_READ |=> !op_grant_r;
  endproperty
  a_iss_ro: assert property (p_iss_ro) else $error("issuer written");

  property p_valid_cause;
    @(posedge clk_in) disable iff (reset_in)
      $rose(code_valid_r) |-> $past(cmp_code) && $past(a) == CODE_HI;
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("bad rise");

  property p_lock_holds;
    @(posedge clk_in) disable iff (reset_in)
      locked_out |=> locked_out && !$rose(code_valid_r);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("lock lost");

  property p_app_erase;
    @(posedge clk_in) disable iff (reset_in)
      op_valid_in && zone == Z_APP1 && op_kind_in == OP_ERASE && issued &&
      !key_one_ok_r |=> !op_grant_r;
  endproperty
  a_app_erase: assert property (p_app_erase) else $error("erase no key");

  property p_test_open;
    @(posedge clk_in) disable iff (reset_in)
      op_valid_in && zone == Z_TEST && op_kind_in != OP_CMP |=> op_grant_r;
  endproperty
  a_test_open: assert property (p_test_open) else $error("test zone shut");

  property p_read_high;
    @(posedge clk_in) disable iff (reset_in)
      op_valid_in && !p_rd |=> data_bit_r;
  endproperty
  a_read_high: assert property (p_read_high) else $error("data leaked");

  property p_cmp_place;
    @(posedge clk_in) disable iff (reset_in)
      op_valid_in && op_kind_in == OP_CMP && zone != Z_CODE &&
      zone != Z_KEY1 && zone != Z_KEY2 |=> !op_grant_r;
  endproperty
  a_cmp_place: assert property (p_cmp_place) else $error("stray compare");

  property p_budget_keep;
    @(posedge clk_in) disable iff (reset_in)
      op_valid_in && zone == Z_BUDG && issued && op_kind_in == OP_ERASE
      |=> !op_grant_r;
  endproperty
  a_budget_keep: assert property (p_budget_keep) else $error("budget erased");

  property p_mismatch;
    @(posedge clk_in) disable iff (reset_in)
      last_bit && cmp_code && (present_bit_in ^ stored_bit_in)
      |=> !code_valid_r;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("bad code valid");

  property p_bus_answer;
    @(posedge clk_in) disable iff (reset_in)
      req && avs_waitrequest_r |=> !avs_waitrequest_r;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no answer");

endmodule

// *** testbench/card_reader_model.sv ***
`timescale 1ns/100ps
module card_reader_model
  import card_access_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              op_done_in,
  input  wire logic              op_grant_in,
  output logic                   op_valid_out,
  output logic [1:0]             op_kind_out,
  output logic [ADDR_W-1:0]      bit_addr_out,
  output logic                   stored_bit_out,
  output logic                   present_bit_out
);
  logic       mem [0:2047];
  logic [1:0] last_kind;
  int         last_addr;
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = i[0];
    op_valid_out = 1'b0;
    op_kind_out = OP_READ;
    bit_addr_out = '0;
    stored_bit_out = 1'b1;
    present_bit_out = 1'b1;
    last_kind = OP_READ;
    last_addr = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one access; f turns the presented bit round
  task automatic op(input logic [1:0] k, input int a, input logic f);
    @(posedge clk_in);
    op_valid_out <= 1'b1;
    op_kind_out <= k;
    bit_addr_out <= ADDR_W'(a);
    stored_bit_out <= mem[a];
    present_bit_out <= mem[a] ^ f;
    last_kind = k;
    last_addr = a;
    @(posedge clk_in);
    op_valid_out <= 1'b0;
    stored_bit_out <= ~mem[a];
    present_bit_out <= ~mem[a];
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reader writes bits, keys too
  always @(posedge clk_in) begin
    if (op_done_in && op_grant_in && last_kind == OP_ERASE) begin
      mem[last_addr] <= 1'b1;
    end
    if (op_done_in && op_grant_in && last_kind == OP_PROG) begin
      mem[last_addr] <= 1'b0;
    end
  end
endmodule

// *** testbench/test_card_access.sv ***
`timescale 1ns/100ps
module test_card_access
  import card_access_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [3:0]  avs_byteenable_in = 4'hf;
  logic        lock_sense_pad_in = 1'b1;
  logic        budget_nonempty_in = 1'b1;
  logic        op_valid_in, stored_bit_in, present_bit_in;
  logic [1:0]  op_kind_in;
  logic [10:0] bit_addr_in;
  logic        op_done_out, op_grant_out, data_bit_out;
  logic [3:0]  zone_out;
  logic        code_valid_out, erase_avail_out, locked_out;
  logic [31:0] q;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int za[27] = '{15, 16, 95, 96, 112, 175, 176, 1199, 1200, 1231, 1232,
    1359, 1360, 1375, 1376, 687, 688, 735, 736, 1247, 1248, 1279, 1280,
    1407, 1408, 1423, 1424};
  logic [3:0] zz[27] = '{Z_FAB, Z_ISS, Z_CODE, Z_TALLY, Z_GUARD, Z_GUARD,
    Z_APP1, Z_APP1, Z_KEY1, Z_KEY1, Z_BUDG, Z_BUDG, Z_TEST, Z_TEST, Z_NONE,
    Z_APP1, Z_KEY1, Z_KEY1, Z_APP2, Z_APP2, Z_KEY2, Z_KEY2, Z_BUDG, Z_BUDG,
    Z_TEST, Z_TEST, Z_NONE};
  always #2 clk_in = ~clk_in;
  card_access u_card_access (.clk_in(clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .lock_sense_pad_in(lock_sense_pad_in), .op_valid_in(op_valid_in),
    .op_kind_in(op_kind_in), .bit_addr_in(bit_addr_in),
    .stored_bit_in(stored_bit_in), .present_bit_in(present_bit_in),
    .budget_nonempty_in(budget_nonempty_in), .op_done_out(op_done_out),
    .op_grant_out(op_grant_out), .data_bit_out(data_bit_out),
    .zone_out(zone_out), .code_valid_out(code_valid_out),
    .erase_avail_out(erase_avail_out), .locked_out(locked_out));
  card_reader_model u_card_reader_model (.clk_in(clk_in),
    .op_done_in(op_done_out), .op_grant_in(op_grant_out),
    .op_valid_out(op_valid_in), .op_kind_out(op_kind_in),
    .bit_addr_out(bit_addr_in), .stored_bit_out(stored_bit_in),
    .present_bit_out(present_bit_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !w;
    avs_write_in <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask
  task automatic stat(input logic [31:0] exp);
    bus(1'b0, REG_STAT, 32'h0);
    chk(q, exp);
  endtask
  // g of 2 leaves the grant unchecked
  task automatic acc(input logic [1:0] k, input int a, input logic f,
                     input int g);
    u_card_reader_model.op(k, a, f);
    @(posedge clk_in);
    chk(32'(op_done_out), 32'h1);
    if (g != 2) chk(32'(op_grant_out), 32'(g));
    if (g == 0 && k == OP_READ) chk(32'(data_bit_out), 32'h1);
    if (g == 1 && k == OP_READ)
      chk(32'(data_bit_out), 32'(u_card_reader_model.mem[a]));
  endtask
  task automatic code(input int lo, input int n, input int bad);
    for (int i = 0; i < n; i++) acc(OP_CMP, lo + i, i == bad, 2);
  endtask
  task automatic sweep(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      acc(OP_READ, za[i], 1'b0, 2);
      chk(32'(zone_out), 32'(zz[i]));
    end
  endtask
  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    do_reset();
    stat(32'h200);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, REG_CTRL, 32'h2);
    stat(32'h280);
    avs_byteenable_in <= 4'he;
    bus(1'b1, REG_CTRL, 32'h4);
    avs_byteenable_in <= 4'hf;
    stat(32'h280);
    sweep(0, 14);
    code(80, 16, 15);
    stat(32'h290);
    acc(OP_READ, 0, 1'b0, 1);
    acc(OP_ERASE, 3, 1'b0, 0);
    acc(OP_PROG, 20, 1'b0, 0);
    acc(OP_READ, 80, 1'b0, 0);
    acc(OP_PROG, 100, 1'b0, 1);
    acc(OP_ERASE, 100, 1'b0, 0);
    acc(OP_READ, 1200, 1'b0, 0);
    acc(OP_ERASE, 120, 1'b0, 0);
    acc(OP_ERASE, 1365, 1'b0, 1);
    acc(OP_CMP, 1365, 1'b0, 0);
    acc(OP_CMP, 30, 1'b0, 0);
    code(80, 16, -1);
    stat(32'h281);
    chk(32'(code_valid_out), 32'h1);
    acc(OP_ERASE, 20, 1'b0, 1);
    acc(OP_READ, 1210, 1'b0, 1);
    acc(OP_PROG, 1210, 1'b0, 1);
    acc(OP_CMP, 85, 1'b0, 0);
    acc(OP_ERASE, 5, 1'b0, 0);
    acc(OP_ERASE, 120, 1'b0, 1);
    acc(OP_ERASE, 176, 1'b0, 1);
    acc(OP_ERASE, 177, 1'b0, 1);
    bus(1'b1, REG_CTRL, 32'h6);
    stat(32'h301);
    acc(OP_ERASE, 20, 1'b0, 0);
    acc(OP_PROG, 2, 1'b0, 0);
    acc(OP_CMP, 80, 1'b0, 0);
    acc(OP_READ, 90, 1'b0, 0);
    acc(OP_PROG, 85, 1'b0, 1);
    acc(OP_READ, 1210, 1'b0, 0);
    acc(OP_PROG, 1240, 1'b0, 1);
    acc(OP_ERASE, 1240, 1'b0, 0);
    acc(OP_ERASE, 300, 1'b0, 0);
    code(1200, 32, -1);
    stat(32'h303);
    acc(OP_ERASE, 300, 1'b0, 1);
    budget_nonempty_in <= 1'b0;
    acc(OP_ERASE, 300, 1'b0, 0);
    chk(32'(erase_avail_out), 32'h0);
    budget_nonempty_in <= 1'b1;
    lock_sense_pad_in <= 1'b0;
    do_reset();
    bus(1'b1, REG_CTRL, 32'h1);
    stat(32'h300);
    sweep(15, 26);
    acc(OP_READ, 300, 1'b0, 0);
    acc(OP_PROG, 2, 1'b0, 0);
    acc(OP_READ, 90, 1'b0, 0);
    acc(OP_ERASE, 120, 1'b0, 0);
    acc(OP_READ, 737, 1'b0, 2);
    acc(OP_READ, 740, 1'b0, 1);
    acc(OP_PROG, 740, 1'b0, 0);
    acc(OP_READ, 200, 1'b0, 0);
    repeat (4) code(80, 16, 0);
    chk(32'(locked_out), 32'h1);
    acc(OP_READ, 0, 1'b0, 0);
    acc(OP_READ, 1410, 1'b0, 1);
    give_verdict();
  end
endmodule
